// File: rtl/asps_pkg.sv
// Purpose: shared constants and types of the supply power sequencer
// Assumes: classic wishbone slave with 32-bit data and byte addresses
// Notes: comparator flags arrive as one packed struct from the analog side

package asps_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_KEY_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int STAT_EN_LSB = 0;
    localparam int STAT_CODE_LSB = 16;
    localparam int STAT_STATE_LSB = 24;

    // ------------------------------------------------------------
    // one-time programmed configuration
    // ------------------------------------------------------------
    localparam int CODE_W = 4;
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_PERI_3V3_LAST = 4'h6;

    typedef enum logic [1:0] {
        CORE_NONE,
        CORE_1V88,
        CORE_2V5,
        CORE_5V0
    } asps_core_e;

    // comparator flags, all active high
    typedef struct packed {
        logic battery_good;      // battery input above start level
        logic ignition_good;     // ignition input above its level
        logic boost_start;       // boost node above start level
        logic boost_hold;        // boost node above final off level
        logic boost_above_inter; // boost node above intermediate output
        logic inter_rise;        // intermediate output above rising level
        logic inter_hold;        // intermediate output above falling level
        logic inter_too_low;     // intermediate output too low
        logic cp_good;           // charge pump voltage adequate
        logic peri_on;           // peripheral output above core-on level
        logic peri_hold;         // peripheral output above core-off level
        logic diff_trip;         // difference above cut-off level
        logic diff_clear;        // difference below cut-off minus hysteresis
    } asps_cmp_s;

    // enables and state shown to the regulators and to software
    typedef struct packed {
        logic diff_cut;
        logic diff_sup;
        logic core_src_boost;
        logic full_cond;
        logic cp_run;
        logic peri_en;
        logic core_run;
        logic core_en;
        logic inter_en;
        logic boost_en;
    } asps_en_s;

    function automatic asps_core_e core_of(input logic [3:0] code);
        asps_core_e m;
        m = CORE_NONE;
        case (code)
            4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9: m = CORE_1V88;
            4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'hC: m = CORE_2V5;
            4'hD, 4'hE, 4'hF: m = CORE_5V0;
            default: m = CORE_NONE;
        endcase
        return m;
    endfunction

endpackage

// File: rtl/asps_sequencer.sv
// Purpose: start-up and power-down sequencing of the airbag supply regulators
// Assumes: comparator flags and otp code are asynchronous to clk_i
// Notes: software sets the key-hold latch over classic wishbone
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.

`timescale 1ns/1ps

// How it works
// - boost runs only with ignition good and battery above its start level
// - a set key-hold latch stands in for ignition good
// - high core modes start intermediate buck and core buck together on boost level
// - peripheral ldo starts only once intermediate output passes its rising level
// - in high core modes core buck runs only with charge pump voltage good
// - 1.88 V core: intermediate alone first, core after peripheral passes on level
// - losing ignition without key-hold latch stops the boost
// - boost stopped in power-down: core buck is fed from the boost node
// - charge pump runs while boost above intermediate and no full conduction
// - intermediate too low enters full conduction, which stops the charge pump
// - peripheral ldo goes off below the intermediate falling level
// - 1.88 V core power-down: core buck stops below peripheral off level
// - intermediate buck goes off last when boost node falls below off level
// - difference supervision active only for 1.88 V core with 3.3 V peripheral
// - supervision trip switches the peripheral ldo off
// - peripheral ldo returns once the difference drops past the hysteresis
module asps_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire asps_pkg::asps_cmp_s cmp_i,
    input wire logic [3:0] otp_code_i,
    output asps_pkg::asps_en_s en_o
);

    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    localparam int CW = $bits(asps_pkg::asps_cmp_s);
    localparam int SW = CW + asps_pkg::CODE_W;

    logic [SW-1:0] sync_w;
    asps_pkg::asps_cmp_s cmp_s;
    logic [3:0] code_s;

    asps_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({otp_code_i, cmp_i}),
        .q_o(sync_w)
    );

    assign cmp_s = sync_w[CW-1:0];
    assign code_s = sync_w[SW-1:CW];

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    asps_pkg::asps_core_e core_mode;
    logic cfg_valid;
    logic hi_core;
    logic lo_core;
    logic sup_active;

    assign core_mode = asps_pkg::core_of(code_s);
    assign cfg_valid = (code_s != asps_pkg::CODE_OFF);
    assign hi_core = (core_mode == asps_pkg::CORE_2V5) ||
                     (core_mode == asps_pkg::CORE_5V0);
    assign lo_core = (core_mode == asps_pkg::CORE_1V88);
    assign sup_active = lo_core &&
                        (code_s <= asps_pkg::CODE_PERI_3V3_LAST);

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic key_hold_q;
    logic key_hold_d;
    logic wb_req;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_key;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] rd_word;

    assign wb_req = wb_cyc_i & wb_stb_i;
    assign ack_d = wb_req & ~ack_q;
    assign hit_ctrl = (wb_adr_i == asps_pkg::CTRL_OFS);
    assign hit_stat = (wb_adr_i == asps_pkg::STAT_OFS);
    assign wr_key = wb_req & ack_q & wb_we_i & hit_ctrl & wb_sel_i[0];
    assign key_hold_d = wr_key ? wb_dat_i[asps_pkg::CTRL_KEY_BIT]
                               : key_hold_q;
    assign rd_word = hit_ctrl ? ctrl_word :
                     hit_stat ? stat_word : 32'h0000_0000;
    assign dat_d = (ack_d & ~wb_we_i) ? rd_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            key_hold_q <= asps_pkg::CTRL_RST[asps_pkg::CTRL_KEY_BIT];
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            key_hold_q <= key_hold_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------
    // sequence state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_BOOST,
        ST_RUN,
        ST_DRAIN
    } asps_state_e;

    asps_state_e state_q;
    asps_state_e state_d;
    logic ign_ok;
    logic boost_go;

    assign ign_ok = cmp_s.ignition_good | key_hold_q;
    assign boost_go = cfg_valid & ign_ok & cmp_s.battery_good;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF: begin
                if (boost_go) begin
                    state_d = ST_BOOST;
                end
            end
            ST_BOOST: begin
                if (!boost_go) begin
                    state_d = ST_OFF;
                end else if (cmp_s.boost_start) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!boost_go) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!cmp_s.boost_hold) begin
                    state_d = ST_OFF;
                end else if (boost_go) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // regulator enables
    // ------------------------------------------------------------
    asps_pkg::asps_en_s en_q;
    asps_pkg::asps_en_s en_d;
    logic peri_on_q;
    logic peri_on_d;
    logic lo_core_q;
    logic lo_core_d;
    logic inter_d;
    logic drain_d;

    assign inter_d = (state_d == ST_RUN) || (state_d == ST_DRAIN);
    assign drain_d = (state_d == ST_DRAIN);
    assign peri_on_d = inter_d & cmp_s.inter_hold &
                       (peri_on_q | cmp_s.inter_rise);
    assign lo_core_d = inter_d & (lo_core_q | cmp_s.peri_on) &
                       ~(drain_d & ~cmp_s.peri_hold);

    assign en_d.boost_en = boost_go;
    assign en_d.inter_en = inter_d;
    assign en_d.full_cond = inter_d &
                            (en_q.full_cond | cmp_s.inter_too_low);
    assign en_d.cp_run = inter_d & cmp_s.boost_above_inter &
                         ~en_d.full_cond;
    assign en_d.core_en = hi_core ? inter_d : (lo_core & lo_core_d);
    assign en_d.core_run = en_d.core_en &
                           (~hi_core | cmp_s.cp_good);
    assign en_d.core_src_boost = drain_d;
    assign en_d.diff_sup = sup_active;
    assign en_d.diff_cut = sup_active & (cmp_s.diff_trip |
                           (en_q.diff_cut & ~cmp_s.diff_clear));
    assign en_d.peri_en = peri_on_d & ~en_d.diff_cut;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_OFF;
            en_q <= '0;
            peri_on_q <= 1'b0;
            lo_core_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_q <= en_d;
            peri_on_q <= peri_on_d;
            lo_core_q <= lo_core_d;
        end
    end

    assign en_o = en_q;

    // ------------------------------------------------------------
    // register words
    // ------------------------------------------------------------
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[asps_pkg::CTRL_KEY_BIT] = key_hold_q;
        stat_word = 32'h0000_0000;
        stat_word[asps_pkg::STAT_EN_LSB +: $bits(asps_pkg::asps_en_s)] =
            en_q;
        stat_word[asps_pkg::STAT_CODE_LSB +: asps_pkg::CODE_W] = code_s;
        stat_word[asps_pkg::STAT_STATE_LSB +: 3] = state_q;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_boost_needs_battery: assert property (@(posedge clk_i)
        disable iff (rst_i)
        en_q.boost_en |-> $past(cmp_s.battery_good))
        else $error("boost enabled without battery level");

    a_key_hold_boost: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (key_hold_q && cmp_s.battery_good && cfg_valid) |=> en_q.boost_en)
        else $error("key hold latch did not keep boost running");

    a_inter_core_together: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($past(hi_core) && $rose(en_q.inter_en)) |-> en_q.core_en)
        else $error("core buck not enabled with intermediate buck");

    a_peri_after_rise: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(peri_on_q) |-> $past(cmp_s.inter_rise))
        else $error("peripheral ldo started before rising level");

    a_core_run_pump: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($past(hi_core) && en_q.core_run) |-> $past(cmp_s.cp_good))
        else $error("core buck running without charge pump voltage");

    a_lo_core_order: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ($past(lo_core) && $rose(en_q.core_en)) |->
            ($past(cmp_s.peri_on) && peri_on_q))
        else $error("low core enabled before peripheral on level");

    a_boost_stop: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!cmp_s.ignition_good && !key_hold_q) |=> !en_q.boost_en)
        else $error("boost still enabled after ignition loss");

    a_drain_source: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (en_q.inter_en && !en_q.boost_en) |-> en_q.core_src_boost)
        else $error("core supply not moved to boost node");

    a_pump_full_cond: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (inter_d && cmp_s.boost_above_inter && !en_d.full_cond)
            |=> en_q.cp_run)
        else $error("charge pump stopped while conditions hold");

    a_full_cond_stop: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (inter_d && cmp_s.inter_too_low) |=>
            (en_q.full_cond && !en_q.cp_run) ##1
            (!en_q.cp_run && (en_q.full_cond == en_q.inter_en)))
        else $error("full conduction did not stop charge pump");

    a_peri_fall_off: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !cmp_s.inter_hold |=> !en_q.peri_en)
        else $error("peripheral ldo on below falling level");

    a_lo_core_stop: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (lo_core && drain_d && !cmp_s.peri_hold) |=> !en_q.core_en)
        else $error("low core not stopped in power-down");

    a_inter_last_off: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (state_q == ST_DRAIN && !cmp_s.boost_hold) |=>
            (!en_q.inter_en && !en_q.peri_en && !en_q.core_en))
        else $error("intermediate buck not switched off last");

    a_sup_gate: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !sup_active |=> (!en_q.diff_sup && !en_q.diff_cut))
        else $error("supervision active in wrong configuration");

    a_diff_cut: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (sup_active && cmp_s.diff_trip) |=> !en_q.peri_en)
        else $error("peripheral ldo not cut on difference trip");

    a_diff_rearm: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (en_q.diff_cut && cmp_s.diff_clear && !cmp_s.diff_trip)
            |=> !en_q.diff_cut)
        else $error("supervision cut not released after hysteresis");

    a_sync_delay: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(cmp_s.battery_good) |-> $past(cmp_i.battery_good, 2))
        else $error("battery flag used without two stages");

    a_ack_single: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_follows_req: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");

    a_read_data_idle: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero outside an ack cycle");

    a_key_latch_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
            (wb_adr_i == asps_pkg::CTRL_OFS)) |=>
            (key_hold_q == $past(wb_dat_i[asps_pkg::CTRL_KEY_BIT])))
        else $error("key hold latch write did not land");

endmodule

// File: rtl/asps_sync.sv
// Purpose: two-stage synchroniser bank for asynchronous flags
// Assumes: synchronous active-high reset
// Notes: first stage feeds only the second stage

`timescale 1ns/1ps

module asps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

// File: verification/asps_analog_model.sv
// Purpose: behavioural regulators, charge pump and comparators
// Assumes: node levels in abstract steps, one step per clock, boost discharge one step per two clocks
// Notes: bench drives battery, ignition and difference flags

`timescale 1ns/1ps

module asps_analog_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic batt_i,
    input wire logic ign_i,
    input wire logic trip_i,
    input wire logic clear_i,
    input wire asps_pkg::asps_en_s en_i,
    output asps_pkg::asps_cmp_s cmp_o
);
    // ----------------------------------------
    // node levels
    // ----------------------------------------
    int bv_q;
    int iv_q;
    int pv_q;
    logic slow_q;

    function automatic int step(input int v, input logic up, input int top);
        if (up) return (v < top) ? v + 1 : top;
        return (v > 0) ? v - 1 : 0;
    endfunction

    // boost discharges at half rate, intermediate falls with the boost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bv_q <= 0;
            iv_q <= 0;
            pv_q <= 0;
            slow_q <= 1'h0;
        end else begin
            slow_q <= ~slow_q;
            if (en_i.boost_en || slow_q) bv_q <= step(bv_q, en_i.boost_en, 20);
            if (!en_i.inter_en) iv_q <= step(iv_q, 1'h0, 16);
            else if (iv_q >= bv_q) iv_q <= bv_q;
            else iv_q <= step(iv_q, 1'h1, 16);
            pv_q <= step(pv_q, en_i.peri_en, 8);
        end
    end

    always_comb begin
        cmp_o.battery_good = batt_i;
        cmp_o.ignition_good = ign_i;
        cmp_o.boost_start = bv_q >= 15;
        cmp_o.boost_hold = bv_q >= 2;
        cmp_o.boost_above_inter = bv_q > iv_q;
        cmp_o.inter_rise = iv_q >= 14;
        cmp_o.inter_hold = iv_q >= 12;
        cmp_o.inter_too_low = en_i.inter_en && iv_q < 15 && bv_q <= iv_q;
        cmp_o.cp_good = en_i.cp_run;
        cmp_o.peri_on = pv_q >= 5;
        cmp_o.peri_hold = pv_q >= 3;
        cmp_o.diff_trip = trip_i;
        cmp_o.diff_clear = clear_i;
    end
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench of the supply power sequencer
// Assumes: analog side given by asps_analog_model
// Notes: one task per scenario, each judged before return

`timescale 1ns/1ps

module tb;
    localparam int B_BOOST = 0;
    localparam int B_INTER = 1;
    localparam int B_CORE = 2;
    localparam int B_RUN = 3;
    localparam int B_PERI = 4;
    localparam int B_CP = 5;
    localparam int B_FULL = 6;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] code = 4'h0;
    logic batt = 1'h0;
    logic ign = 1'h0;
    logic trip = 1'h0;
    logic clr = 1'h1;
    asps_pkg::asps_cmp_s cmp;
    asps_pkg::asps_en_s en;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    asps_sequencer dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_i(cmp),
        .otp_code_i(code), .en_o(en));

    asps_analog_model ana (.clk_i(clk), .rst_i(rst), .batt_i(batt),
        .ign_i(ign), .trip_i(trip), .clear_i(clr), .en_i(en), .cmp_o(cmp));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_en(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (en[b] !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk(en[b], v);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1);
        r = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        chk(n, 32'h0000_0002);
    endtask

    task automatic do_reset(input logic [3:0] c);
        @(posedge clk);
        rst <= 1'h1;
        code <= c;
        batt <= 1'h0;
        ign <= 1'h0;
        trip <= 1'h0;
        clr <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        chk(en, 10'h000);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_key();
        logic [31:0] r;
        do_reset(4'h4);
        wb(1'h0, asps_pkg::CTRL_OFS, 4'hF, 32'h0000_0000, r);
        chk(r, asps_pkg::CTRL_RST);
        wb(1'h0, 8'h10, 4'hF, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        @(posedge clk);
        ign <= 1'h1;
        tick(10);
        chk(en.boost_en, 1'h0);
        @(posedge clk);
        ign <= 1'h0;
        wb(1'h1, asps_pkg::CTRL_OFS, 4'h1, 32'h0000_0001, r);
        wb(1'h1, asps_pkg::CTRL_OFS, 4'h0, 32'h0000_0000, r);
        wb(1'h1, asps_pkg::STAT_OFS, 4'hF, 32'hFFFF_FFFF, r);
        wb(1'h0, asps_pkg::CTRL_OFS, 4'hF, 32'h0000_0000, r);
        chk(r, 32'h0000_0001);
        @(posedge clk);
        batt <= 1'h1;
        tick(2);
        chk(en.boost_en, 1'h0);
        tick(1);
        chk(en.boost_en, 1'h1);
        wb(1'h0, asps_pkg::STAT_OFS, 4'hF, 32'h0000_0000, r);
        chk(r[9:0], 10'h001);
        chk(r[19:16], 4'h4);
        chk(r[26:24], 3'h1);
        wb(1'h1, asps_pkg::CTRL_OFS, 4'h1, 32'h0000_0000, r);
        wait_en(B_BOOST, 1'h0, 5);
    endtask

    task automatic s_high(input logic [3:0] c);
        do_reset(c);
        @(posedge clk);
        batt <= 1'h1;
        ign <= 1'h1;
        wait_en(B_BOOST, 1'h1, 5);
        wait_en(B_INTER, 1'h1, 40);
        chk(en.core_en, 1'h1);
        wait_en(B_PERI, 1'h1, 40);
        chk(cmp.inter_rise, 1'h1);
        wait_en(B_RUN, 1'h1, 10);
        chk(cmp.cp_good, 1'h1);
        @(posedge clk);
        trip <= 1'h1;
        clr <= 1'h0;
        tick(8);
        chk({en.diff_sup, en.peri_en}, 2'h1);
        @(posedge clk);
        trip <= 1'h0;
        clr <= 1'h1;
        ign <= 1'h0;
        wait_en(B_BOOST, 1'h0, 5);
        chk(en.core_src_boost, 1'h1);
        chk(en.cp_run, 1'h1);
        wait_en(B_FULL, 1'h1, 40);
        wait_en(B_CP, 1'h0, 2);
        wait_en(B_RUN, 1'h0, 5);
        wait_en(B_PERI, 1'h0, 40);
        chk({cmp.inter_hold, en.inter_en}, 2'h1);
        wait_en(B_INTER, 1'h0, 60);
        chk(cmp.boost_hold, 1'h0);
    endtask

    task automatic s_low();
        do_reset(4'h1);
        @(posedge clk);
        batt <= 1'h1;
        ign <= 1'h1;
        wait_en(B_INTER, 1'h1, 40);
        chk({en.diff_sup, en.core_en}, 2'h2);
        wait_en(B_PERI, 1'h1, 40);
        chk(en.core_en, 1'h0);
        wait_en(B_CORE, 1'h1, 10);
        chk(cmp.peri_on, 1'h1);
        @(posedge clk);
        trip <= 1'h1;
        clr <= 1'h0;
        wait_en(B_PERI, 1'h0, 4);
        chk(en.diff_cut, 1'h1);
        @(posedge clk);
        trip <= 1'h0;
        tick(8);
        chk(en.peri_en, 1'h0);
        @(posedge clk);
        clr <= 1'h1;
        wait_en(B_PERI, 1'h1, 4);
        tick(12);
        @(posedge clk);
        ign <= 1'h0;
        wait_en(B_BOOST, 1'h0, 5);
        wait_en(B_PERI, 1'h0, 60);
        wait_en(B_CORE, 1'h0, 40);
        chk({cmp.peri_hold, en.inter_en}, 2'h1);
        wait_en(B_INTER, 1'h0, 60);
    endtask

    task automatic s_off();
        do_reset(4'h0);
        @(posedge clk);
        batt <= 1'h1;
        ign <= 1'h1;
        tick(30);
        chk(en, 10'h000);
    endtask

    initial begin
        s_key();
        s_high(4'h4);
        s_high(4'hD);
        s_low();
        s_off();
        close_out();
    end
endmodule
